// ---- hw/aof_formatter.sv ----
// Digital output stage of a 16-bit pipelined ADC: coding, range flags,
// dither removal, randomizer, CMOS/LVDS bus steering and sample strobes.
// Assumes straps and pins are asynchronous to sys_clk; converter words
// arrive synchronous to sample_clock_in.
`timescale 1ns/10ps
module aof_formatter #(
  parameter int DITHER_W = 8,
  parameter int PIPE_LAT = 4
) (
  // System clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Strap and control pins
  input wire logic [1:0] format_strap,
  input wire logic [1:0] output_mode_strap,
  input wire logic scramble_enable,
  input wire logic dither_enable,
  // Encode clock and converter core
  input wire logic sample_clock_in,
  input wire logic [aof_pkg::DATA_W-1:0] conv_data,
  input wire logic conv_over,
  input wire logic conv_under,
  // Dither converter drive
  output logic [DITHER_W-1:0] dither_code,
  // Output buses and flags
  output logic [aof_pkg::DATA_W-1:0] bus_a_data,
  output logic [aof_pkg::DATA_W-1:0] bus_b_data,
  output logic overrange_a,
  output logic overrange_b,
  output logic overflow_flag,
  // Strobes
  output logic strobe_out_a,
  output logic strobe_out_b,
  output logic sample_strobe_out,
  // Driver and clock status
  output logic lvds_enable,
  output logic lvds_low_power,
  output logic stabiliser_on,
  output logic stabiliser_locked
);
  localparam int W = aof_pkg::DATA_W;

  // System domain: strap synchronisers
  logic [1:0] fmt_m, fmt_s, mode_m, mode_s;
  logic scr_m, scr_s, dith_m, dith_s;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {fmt_m, fmt_s, mode_m, mode_s} <= 8'h00;
      {scr_m, scr_s, dith_m, dith_s} <= 4'h0;
    end else begin
      {fmt_s, fmt_m} <= {fmt_m, format_strap};
      {mode_s, mode_m} <= {mode_m, output_mode_strap};
      {scr_s, scr_m} <= {scr_m, scramble_enable};
      {dith_s, dith_m} <= {dith_m, dither_enable};
    end
  end

  // System domain: strap decode
  aof_pkg::aof_mode_type mode_r;
  logic two_comp_r, dcs_r, scr_r, dith_r;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_r <= aof_pkg::AOF_MODE_FULL;
      {two_comp_r, dcs_r, scr_r, dith_r} <= 4'h0;
    end else begin
      two_comp_r <= fmt_s[1];
      dcs_r <= fmt_s[1] ^ fmt_s[0];
      scr_r <= scr_s;
      dith_r <= dith_s;
      case (mode_s)
        aof_pkg::STRAP_GND: mode_r <= aof_pkg::AOF_MODE_FULL;
        aof_pkg::STRAP_THIRD: mode_r <= aof_pkg::AOF_MODE_DEMUX;
        aof_pkg::STRAP_TWO_THIRD: mode_r <= aof_pkg::AOF_MODE_LVDS_LP;
        default: mode_r <= aof_pkg::AOF_MODE_LVDS;
      endcase
    end
  end
  assign stabiliser_on = dcs_r;

  // System domain: encode clock stop watchdog and lock status return
  logic hb_r, hb_m, hb_s, hb_d, stopped_r, lk_m, lk_s, locked_l, locked_r;
  logic [aof_pkg::STOP_CNT_W-1:0] idle_cnt_r;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {hb_m, hb_s, hb_d} <= 3'h0;
      idle_cnt_r <= '0;
      stopped_r <= 1'h0;
      {lk_m, lk_s, locked_r} <= 3'h0;
    end else begin
      hb_m <= hb_r;
      hb_s <= hb_m;
      hb_d <= hb_s;
      lk_m <= locked_l;
      lk_s <= lk_m;
      // A stopped clock freezes the encode side, so lock is masked here
      locked_r <= lk_s && !stopped_r;
      if (hb_s != hb_d) begin
        idle_cnt_r <= '0;
        // Stay stopped until the encode side has dropped its old lock
        stopped_r <= stopped_r && lk_s;
      end else if (idle_cnt_r ==
          aof_pkg::STOP_CNT_W'(aof_pkg::STOP_CYCLES)) begin
        stopped_r <= 1'h1;
      end else begin
        idle_cnt_r <= idle_cnt_r + 1'h1;
      end
    end
  end
  assign stabiliser_locked = locked_r;

  // Encode domain: reset and control synchronisers
  logic lrst_m, lrst;
  logic [aof_pkg::CTL_W-1:0] ctl_m, ctl_s, ctl_d, ctl_q;
  logic stop_m, stop_s;
  always_ff @(posedge sample_clock_in) begin
    lrst_m <= rst;
    lrst <= lrst_m;
  end
  always_ff @(posedge sample_clock_in) begin
    if (lrst) begin
      ctl_m <= aof_pkg::CTL_RESET;
      ctl_s <= aof_pkg::CTL_RESET;
      ctl_d <= aof_pkg::CTL_RESET;
      ctl_q <= aof_pkg::CTL_RESET;
      {stop_m, stop_s} <= 2'h0;
    end else begin
      ctl_m <= {mode_r, two_comp_r, dcs_r, scr_r, dith_r};
      ctl_s <= ctl_m;
      ctl_d <= ctl_s;
      // Take the word only when two samples agree, so fields move together
      if (ctl_s == ctl_d) begin
        ctl_q <= ctl_d;
      end
      stop_m <= stopped_r;
      stop_s <= stop_m;
    end
  end

  aof_pkg::aof_mode_type mode_l;
  logic two_comp_l, dcs_l, scr_l, dith_l, full_l, demux_l, lvds_l;
  always_comb begin
    mode_l = aof_pkg::aof_mode_type'(ctl_q[aof_pkg::CTL_MODE_LSB +: 4]);
    two_comp_l = ctl_q[aof_pkg::CTL_TWO_COMP];
    dcs_l = ctl_q[aof_pkg::CTL_DCS];
    scr_l = ctl_q[aof_pkg::CTL_SCR];
    dith_l = ctl_q[aof_pkg::CTL_DITH];
    full_l = mode_l == aof_pkg::AOF_MODE_FULL;
    demux_l = mode_l == aof_pkg::AOF_MODE_DEMUX;
    lvds_l = !full_l && !demux_l;
  end
  assign lvds_enable = lvds_l;
  assign lvds_low_power = mode_l == aof_pkg::AOF_MODE_LVDS_LP;

  // Encode domain: heartbeat and stabiliser relock counter
  aof_pkg::aof_lock_type lock_st_r;
  logic [aof_pkg::RELOCK_CNT_W-1:0] lock_cnt_r;
  always_ff @(posedge sample_clock_in) begin
    if (lrst) begin
      hb_r <= 1'h0;
    end else begin
      hb_r <= ~hb_r;
    end
  end
  always_ff @(posedge sample_clock_in) begin
    if (lrst || stop_s) begin
      lock_st_r <= aof_pkg::AOF_LK_COUNT;
      lock_cnt_r <= '0;
    end else begin
      case (lock_st_r)
        aof_pkg::AOF_LK_COUNT: begin
          if (!dcs_l || lock_cnt_r ==
              aof_pkg::RELOCK_CNT_W'(aof_pkg::RELOCK_CYCLES - 1)) begin
            lock_st_r <= aof_pkg::AOF_LK_LOCKED;
          end else begin
            lock_cnt_r <= lock_cnt_r + 1'h1;
          end
        end
        aof_pkg::AOF_LK_LOCKED: lock_st_r <= aof_pkg::AOF_LK_LOCKED;
        default: lock_st_r <= aof_pkg::AOF_LK_COUNT;
      endcase
    end
  end
  assign locked_l = lock_st_r == aof_pkg::AOF_LK_LOCKED;

  // Encode domain: dither generator and latency-matched delay line
  logic [aof_pkg::LFSR_W-1:0] lfsr_r;
  logic [DITHER_W-1:0] dither_code_r;
  logic [DITHER_W-1:0] dly_r [PIPE_LAT];
  logic [W:0] sub_ext, diff;
  always_ff @(posedge sample_clock_in) begin
    if (lrst) begin
      lfsr_r <= aof_pkg::LFSR_SEED;
      dither_code_r <= '0;
    end else if (dith_l) begin
      lfsr_r <= {lfsr_r[aof_pkg::LFSR_W-2:0],
        lfsr_r[aof_pkg::LFSR_TAP_A] ^ lfsr_r[aof_pkg::LFSR_TAP_B]};
      dither_code_r <= lfsr_r[DITHER_W-1:0];
    end else begin
      dither_code_r <= '0;
    end
  end
  always_ff @(posedge sample_clock_in) begin
    if (lrst) begin
      for (int i = 0; i < PIPE_LAT; i++) begin
        dly_r[i] <= '0;
      end
    end else begin
      dly_r[0] <= dither_code_r;
      for (int i = 1; i < PIPE_LAT; i++) begin
        dly_r[i] <= dly_r[i-1];
      end
    end
  end
  assign dither_code = dither_code_r;

  // Encode domain: dither removal and range flag
  aof_word_if #(.W(W)) word_in ();
  aof_word_if #(.W(W)) word_out ();
  always_comb begin
    sub_ext = '0;
    if (dith_l) begin
      sub_ext[DITHER_W-1:0] = dly_r[PIPE_LAT-1];
    end
    diff = {1'h0, conv_data} - sub_ext;
  end
  always_ff @(posedge sample_clock_in) begin
    if (lrst) begin
      word_in.data <= '0;
      word_in.ovf <= 1'h0;
    end else begin
      word_in.data <= diff[W] ? '0 : diff[W-1:0];
      word_in.ovf <= conv_over || conv_under || diff[W];
    end
  end

  aof_word_stage #(.W(W)) u_word_stage (
    .clk(sample_clock_in),
    .rst(lrst),
    .two_comp(two_comp_l),
    .scramble(scr_l),
    .in_w(word_in),
    .out_w(word_out)
  );

  // Encode domain: bus steering per output mode
  logic div_r, hold_ovf_r;
  logic [W-1:0] hold_data_r;
  always_ff @(posedge sample_clock_in) begin
    if (lrst) begin
      div_r <= 1'h0;
      hold_data_r <= '0;
      hold_ovf_r <= 1'h0;
      bus_a_data <= '0;
      bus_b_data <= '0;
      {overrange_a, overrange_b, overflow_flag} <= 3'h0;
    end else begin
      div_r <= demux_l ? ~div_r : 1'h0;
      case (mode_l)
        aof_pkg::AOF_MODE_DEMUX: begin
          overflow_flag <= 1'h0;
          if (div_r) begin
            bus_a_data <= hold_data_r;
            overrange_a <= hold_ovf_r;
            bus_b_data <= word_out.data;
            overrange_b <= word_out.ovf;
          end else begin
            hold_data_r <= word_out.data;
            hold_ovf_r <= word_out.ovf;
          end
        end
        aof_pkg::AOF_MODE_FULL: begin
          bus_a_data <= word_out.data;
          overrange_a <= word_out.ovf;
          bus_b_data <= '0;
          overrange_b <= 1'h0;
          overflow_flag <= 1'h0;
        end
        default: begin
          bus_a_data <= word_out.data;
          overflow_flag <= word_out.ovf;
          bus_b_data <= '0;
          {overrange_a, overrange_b} <= 2'h0;
        end
      endcase
    end
  end

  // Strobes: inverted encode clock on strobe_out_a and sample_strobe_out, div_r in demux, so bus updates meet the falling edge
  always_comb begin
    strobe_out_a = 1'h0;
    strobe_out_b = 1'h0;
    sample_strobe_out = 1'h0;
    case (mode_l)
      aof_pkg::AOF_MODE_FULL: begin
        strobe_out_a = ~sample_clock_in;
        strobe_out_b = sample_clock_in;
      end
      aof_pkg::AOF_MODE_DEMUX: begin
        strobe_out_a = div_r;
        strobe_out_b = ~div_r;
      end
      default: sample_strobe_out = ~sample_clock_in;
    endcase
  end

  // System domain checks
  property p_fmt_two_third;
    @(posedge sys_clk) disable iff (rst)
    fmt_s == aof_pkg::STRAP_TWO_THIRD |=> two_comp_r && dcs_r;
  endproperty
  a_fmt_two_third: assert property (p_fmt_two_third)
    else $error("format strap 2/3 decode");

  property p_fmt_supply;
    @(posedge sys_clk) disable iff (rst)
    fmt_s == aof_pkg::STRAP_SUPPLY |=> two_comp_r && !dcs_r;
  endproperty
  a_fmt_supply: assert property (p_fmt_supply)
    else $error("format strap supply decode");

  property p_mode_demux;
    @(posedge sys_clk) disable iff (rst)
    mode_s == aof_pkg::STRAP_THIRD |=> mode_r == aof_pkg::AOF_MODE_DEMUX;
  endproperty
  a_mode_demux: assert property (p_mode_demux)
    else $error("mode strap 1/3 decode");

  // Encode domain checks
  sequence s_ovf_pipe;
    ##1 word_in.ovf ##1 word_out.ovf;
  endsequence

  property p_ovf_cmos;
    @(posedge sample_clock_in) disable iff (lrst)
    full_l && conv_over |->
      s_ovf_pipe ##1 (overrange_a || !$past(full_l));
  endproperty
  a_ovf_cmos: assert property (p_ovf_cmos)
    else $error("bus A range flag missing");

  property p_ovf_lvds;
    @(posedge sample_clock_in) disable iff (lrst)
    lvds_l && conv_under |->
      s_ovf_pipe ##1 (overflow_flag || !$past(lvds_l));
  endproperty
  a_ovf_lvds: assert property (p_ovf_lvds)
    else $error("LVDS overflow flag missing");

  property p_demux_hold;
    @(posedge sample_clock_in) disable iff (lrst)
    demux_l && !div_r ##1 demux_l |-> $stable(bus_a_data) &&
      $stable(bus_b_data);
  endproperty
  a_demux_hold: assert property (p_demux_hold)
    else $error("demux bus changed off strobe fall");

  property p_full_bus_b;
    @(posedge sample_clock_in) disable iff (lrst)
    full_l ##1 full_l |-> bus_b_data == '0 && !overrange_b;
  endproperty
  a_full_bus_b: assert property (p_full_bus_b)
    else $error("bus B active in full rate");

  sequence s_half_rate;
    !div_r ##1 div_r;
  endsequence

  property p_half_rate;
    @(posedge sample_clock_in) disable iff (lrst)
    demux_l && div_r ##1 demux_l |-> s_half_rate;
  endproperty
  a_half_rate: assert property (p_half_rate)
    else $error("demux strobe not half rate");

  property p_dither_gen;
    @(posedge sample_clock_in) disable iff (lrst)
    dith_l |=> dither_code == $past(lfsr_r[DITHER_W-1:0]);
  endproperty
  a_dither_gen: assert property (p_dither_gen)
    else $error("dither code not from sequence");

  property p_dither_sub;
    @(posedge sample_clock_in) disable iff (lrst)
    !diff[W] |=> word_in.data + $past(sub_ext[W-1:0]) == $past(conv_data);
  endproperty
  a_dither_sub: assert property (p_dither_sub)
    else $error("dither not removed");

  property p_relock;
    @(posedge sample_clock_in) disable iff (lrst)
    $rose(locked_l) && dcs_l |-> $past(lock_cnt_r) ==
      aof_pkg::RELOCK_CNT_W'(aof_pkg::RELOCK_CYCLES - 1);
  endproperty
  a_relock: assert property (p_relock)
    else $error("stabiliser locked early");
endmodule : aof_formatter

// ---- hw/aof_pkg.sv ----
// Shared constants and types for the ADC output formatter
// Assumes the converter core hands over offset-binary words on the encode clock
package aof_pkg;
  localparam int DATA_W = 16;
  // Four-level strap codes after the analog level detector
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_THIRD = 2'h1;
  localparam logic [1:0] STRAP_TWO_THIRD = 2'h2;
  localparam logic [1:0] STRAP_SUPPLY = 2'h3;
  typedef enum logic [3:0] {
    AOF_MODE_FULL = 4'h1,
    AOF_MODE_DEMUX = 4'h2,
    AOF_MODE_LVDS_LP = 4'h4,
    AOF_MODE_LVDS = 4'h8
  } aof_mode_type;
  typedef enum logic [1:0] {
    AOF_LK_COUNT = 2'h1,
    AOF_LK_LOCKED = 2'h2
  } aof_lock_type;
  // Control word fields carried into the encode clock domain
  localparam int CTL_W = 8;
  localparam int CTL_MODE_LSB = 4;
  localparam int CTL_TWO_COMP = 3;
  localparam int CTL_DCS = 2;
  localparam int CTL_SCR = 1;
  localparam int CTL_DITH = 0;
  localparam logic [7:0] CTL_RESET = 8'h10;
  // Timing
  localparam int SYS_CLK_MHZ = 50;
  localparam int STOP_NS = 2000;
  localparam int STOP_CYCLES = (STOP_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int STOP_CNT_W = 8;
  localparam int RELOCK_CYCLES = 100;
  localparam int RELOCK_CNT_W = 7;
  // Dither sequence generator, x^23 + x^18 + 1
  localparam int LFSR_W = 23;
  localparam int LFSR_TAP_A = 22;
  localparam int LFSR_TAP_B = 17;
  localparam logic [22:0] LFSR_SEED = 23'h00_0001;
endpackage : aof_pkg

// ---- hw/aof_word_if.sv ----
// Word carrier between the formatter stages: data word and its range flag
// Assumes both ends run on the encode clock
`timescale 1ns/10ps
interface aof_word_if #(parameter int W = aof_pkg::DATA_W);
  logic [W-1:0] data;
  logic ovf;
  modport src (output data, output ovf);
  modport sink (input data, input ovf);
endinterface : aof_word_if

// ---- hw/aof_word_stage.sv ----
// Output coding stage: two's complement conversion and XOR randomizer
// Assumes controls are already synchronous to clk
`timescale 1ns/10ps
module aof_word_stage #(parameter int W = aof_pkg::DATA_W) (
  // Encode clock and its reset
  input wire logic clk,
  input wire logic rst,
  // Coding controls
  input wire logic two_comp,
  input wire logic scramble,
  // Words in and out
  aof_word_if.sink in_w,
  aof_word_if.src out_w
);
  logic [W-1:0] fmt;

  always_comb begin
    fmt = in_w.data;
    fmt[W-1] = in_w.data[W-1] ^ two_comp;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      out_w.data <= '0;
      out_w.ovf <= 1'h0;
    end else begin
      if (scramble) begin
        out_w.data <= {fmt[W-1:1] ^ {(W-1){fmt[0]}}, fmt[0]};
      end else begin
        out_w.data <= fmt;
      end
      out_w.ovf <= in_w.ovf;
    end
  end

  property p_scramble;
    @(posedge clk) disable iff (rst)
    scramble |=> out_w.data[0] == $past(fmt[0]) &&
      (out_w.data[W-1:1] ^ {(W-1){out_w.data[0]}}) == $past(fmt[W-1:1]);
  endproperty
  a_scramble: assert property (p_scramble) else $error("randomizer wrong");

  property p_plain;
    @(posedge clk) disable iff (rst)
    !scramble |=> out_w.data[W-2:0] == $past(in_w.data[W-2:0]) &&
      out_w.ovf == $past(in_w.ovf);
  endproperty
  a_plain: assert property (p_plain) else $error("plain data altered");

  property p_coding;
    @(posedge clk) disable iff (rst)
    !scramble |=> out_w.data[W-1] == ($past(in_w.data[W-1]) ^ $past(two_comp));
  endproperty
  a_coding: assert property (p_coding) else $error("sign coding wrong");
endmodule : aof_word_stage

// ---- dv/aof_capture_model.sv ----
// Capture model: latches the output buses the way downstream logic would
// Assumes mode and scr mirror the straps and pin given to the design
`timescale 1ns/10ps
module aof_capture_model (
  // Settings seen by the capturing side
  input wire logic [1:0] mode,
  input wire logic scr,
  // Device outputs
  input wire logic [15:0] bus_a,
  input wire logic [15:0] bus_b,
  input wire logic ovr_a,
  input wire logic ovr_b,
  input wire logic ovf,
  input wire logic stb_a,
  input wire logic stb_lvds
);
  logic [16:0] q[$];
  int a_rise = 0;
  int l_rise = 0;

  // Undo the output randomizer before storing
  function automatic logic [16:0] grab(logic f, logic [15:0] d);
    logic [15:0] m;
    m = scr ? {{15{d[0]}}, 1'h0} : 16'h0000;
    return {f, d ^ m};
  endfunction : grab

  always @(posedge stb_a) begin
    a_rise++;
    if (mode == 2'h0) begin
      q.push_back(grab(ovr_a, bus_a));
    end else if (mode == 2'h1) begin
      q.push_back(grab(ovr_a, bus_a));
      q.push_back(grab(ovr_b, bus_b));
    end
  end

  always @(posedge stb_lvds) begin
    l_rise++;
    if (mode[1]) begin
      q.push_back(grab(ovf, bus_a));
    end
  end
endmodule : aof_capture_model

// ---- dv/adc_output_formatter_tb.sv ----
// Self-checking bench for the ADC output formatter
// Assumes the capture model sits on the output buses and strobes
`timescale 1ns/10ps
module adc_output_formatter_tb;
  localparam int PL = 1;
  localparam logic [15:0] CORNER [4] = '{16'h0000, 16'h8000, 16'h7FFF,
    16'hFDFF};
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic [1:0] fmt = 2'h0;
  logic [1:0] mode = 2'h0;
  logic scr = 1'h0;
  logic dith = 1'h0;
  logic sample_clock_in = 1'h0;
  logic [15:0] conv_data = 16'h0000;
  logic conv_over = 1'h0;
  logic conv_under = 1'h0;
  logic [7:0] dither_code;
  logic [15:0] bus_a_data;
  logic [15:0] bus_b_data;
  logic overrange_a, overrange_b, overflow_flag;
  logic strobe_out_a, strobe_out_b, sample_strobe_out;
  logic lvds_enable, lvds_low_power, stabiliser_on, stabiliser_locked;
  logic enc_run = 1'h1;
  logic rec = 1'h0;
  logic [7:0] dh [8] = '{default: 8'h00};
  logic [16:0] sq[$];
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #10 sys_clk = ~sys_clk;
  // Encode clock, offset in phase, stands low while stopped
  initial begin
    #1.3;
    forever #6 sample_clock_in = enc_run ? ~sample_clock_in : 1'h0;
  end

  aof_formatter #(.DITHER_W(8), .PIPE_LAT(PL)) dut (
    .sys_clk(sys_clk), .rst(rst), .format_strap(fmt),
    .output_mode_strap(mode), .scramble_enable(scr),
    .dither_enable(dith), .sample_clock_in(sample_clock_in),
    .conv_data(conv_data), .conv_over(conv_over),
    .conv_under(conv_under), .dither_code(dither_code),
    .bus_a_data(bus_a_data), .bus_b_data(bus_b_data),
    .overrange_a(overrange_a), .overrange_b(overrange_b),
    .overflow_flag(overflow_flag), .strobe_out_a(strobe_out_a),
    .strobe_out_b(strobe_out_b), .sample_strobe_out(sample_strobe_out),
    .lvds_enable(lvds_enable), .lvds_low_power(lvds_low_power),
    .stabiliser_on(stabiliser_on), .stabiliser_locked(stabiliser_locked)
  );

  aof_capture_model cap (
    .mode(mode), .scr(scr), .bus_a(bus_a_data), .bus_b(bus_b_data),
    .ovr_a(overrange_a), .ovr_b(overrange_b), .ovf(overflow_flag),
    .stb_a(strobe_out_a), .stb_lvds(sample_strobe_out)
  );

  function automatic logic [16:0] exp_word(logic [15:0] s, logic f);
    if (fmt[1]) begin
      s[15] = ~s[15];
    end
    return {f, s};
  endfunction : exp_word

  task automatic chk_word(input logic [16:0] g, input logic [16:0] e,
                          input string m);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk_word

  task automatic chk_bit(input logic g, input logic e, input string m);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t %s got %b exp %b", $time, m, g, e);
    end
  endtask : chk_bit

  task automatic stop_test;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  // Converter core: random sample plus the dither it was handed
  always @(negedge sample_clock_in) begin : core
    logic [15:0] s;
    logic o, u;
    // Dither history, read where it has settled: dh[k] is k cycles old
    for (int i = 7; i > 0; i--) begin
      dh[i] = dh[i-1];
    end
    dh[0] = dither_code;
    s = 16'($urandom_range(32'h0000_FE00));
    if (rec && sq.size() < 4) begin
      s = CORNER[sq.size()];
    end
    o = ($urandom % 8) == 0;
    u = !o && ($urandom % 8) == 1;
    conv_data <= s + 16'(dh[PL]);
    conv_over <= o;
    conv_under <= u;
    if (rec) begin
      sq.push_back(exp_word(s, o | u));
    end
  end

  task automatic run_cfg(input logic [1:0] f, input logic [1:0] md,
                         input logic sc, input logic dt);
    int i;
    int n;
    @(negedge sys_clk);
    fmt = f;
    mode = md;
    scr = sc;
    dith = dt;
    repeat (40) @(negedge sys_clk);
    chk_bit(stabiliser_on, f == 2'h1 || f == 2'h2, "stab on");
    chk_bit(lvds_enable, md[1], "lvds en");
    chk_bit(lvds_low_power, md == 2'h2, "lvds lp");
    if (!dt) begin
      chk_word({9'h000, dither_code}, 17'h0_0000, "dither off");
    end
    cap.a_rise = 0;
    cap.l_rise = 0;
    repeat (24) @(negedge sys_clk);
    chk_word(17'(cap.l_rise), md[1] ? 17'h0_0028 : 17'h0_0000, "lvds stb");
    if (!md[1]) begin
      chk_word(17'(cap.a_rise), md[0] ? 17'h0_0014 : 17'h0_0028, "stb a");
      chk_bit(strobe_out_b, ~strobe_out_a, "stb b");
    end
    cap.q.delete();
    sq.delete();
    rec = 1'h1;
    wait (sq.size() == 32);
    rec = 1'h0;
    repeat (12) @(posedge sample_clock_in);
    n = -1;
    for (i = 0; i < 8 && i < cap.q.size(); i++) begin
      if (n < 0 && cap.q[i] === sq[0]) begin
        n = i;
      end
    end
    if (n < 0) begin
      miscompares++;
      $display("[ERR] %0t no aligned output word", $time);
    end else begin
      for (i = 0; i < 32 && n + i < cap.q.size(); i++) begin
        chk_word(cap.q[n+i], sq[i], "word");
      end
    end
  endtask : run_cfg

  task automatic relock(input logic [1:0] f);
    @(negedge sys_clk);
    fmt = f;
    repeat (40) @(negedge sys_clk);
    chk_bit(stabiliser_locked, 1'h1, "locked");
    enc_run = 1'h0;
    repeat (150) @(negedge sys_clk);
    chk_bit(stabiliser_locked, 1'h0, "stopped");
    enc_run = 1'h1;
    if (f == 2'h1) begin
      repeat (80) @(posedge sample_clock_in);
      @(negedge sys_clk);
      chk_bit(stabiliser_locked, 1'h0, "early lock");
      repeat (45) @(posedge sample_clock_in);
    end else begin
      repeat (24) @(posedge sample_clock_in);
    end
    @(negedge sys_clk);
    chk_bit(stabiliser_locked, 1'h1, "relock");
  endtask : relock

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      miscompares++;
      stop_test();
    end
  end

  initial begin
    void'($urandom(62296));
    repeat (4) @(negedge sys_clk);
    rst = 1'h0;
    repeat (10) @(negedge sys_clk);
    for (int f = 0; f < 4; f++) begin
      for (int m = 0; m < 4; m++) begin
        run_cfg(2'(f), 2'(m), 1'(m ^ (f >> 1)), 1'(f ^ (m >> 1)));
      end
    end
    relock(2'h1);
    relock(2'h0);
    stop_test();
  end
endmodule : adc_output_formatter_tb
